// ===== hw/sld_pkg.sv
// Shared constants and types of the synchronous line driver control block.
package sld_pkg;
   // ********************************************************************
   // Clock and timing
   // ********************************************************************
   localparam int unsigned CORE_CLK_HZ = 125_000_000;
   localparam int unsigned CYC_PER_MS  = CORE_CLK_HZ / 1000;
   localparam int unsigned DLY_A_MS    = 0;
   localparam int unsigned DLY_B_MS    = 11;
   localparam int unsigned DLY_C_MS    = 50;
   localparam int unsigned DLY_D_MS    = 175;
   localparam int unsigned DLY_CNT_W   = 25;
   localparam int unsigned DIV_W       = 16;
   localparam int unsigned SYNC_N      = 6;
   // ********************************************************************
   // Line rates and their switch patterns {bank high 8, bank low 4}
   // ********************************************************************
   localparam int unsigned NUM_RATES = 10;
   localparam int unsigned RATE_BPS [NUM_RATES] = '{
      2400, 4800, 9600, 19200, 38400, 56000, 64000, 112000, 128000, 256000};
   localparam logic [11:0] RATE_PAT [NUM_RATES] = '{
      12'hfd9, 12'hd97, 12'hd93, 12'hd91, 12'hd90,
      12'hf50, 12'hd50, 12'hf20, 12'hd20, 12'h620};
   localparam logic [3:0]  RATE_IDX_RST = 4'h5;
   // ********************************************************************
   // Register map
   // ********************************************************************
   localparam int unsigned AXI_AW    = 8;
   localparam logic [7:0]  REG_CFG   = 8'h00;
   localparam logic [7:0]  REG_STAT  = 8'h04;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam int unsigned CFG_RATE_LSB = 0;
   localparam int unsigned CFG_SRC_LSB  = 12;
   localparam int unsigned CFG_TERM_BIT = 15;
   localparam int unsigned CFG_CAR_LSB  = 16;
   localparam int unsigned CFG_HALF_BIT = 19;
   localparam logic [2:0]  SRC_RST  = 3'h2;
   localparam logic        TERM_RST = 1'b1;
   localparam logic [2:0]  CAR_RST  = 3'h2;
   localparam logic [2:0]  CAR_CONST = 3'h0;
   localparam logic        HALF_RST = 1'b0;
   localparam logic [31:0] CFG_RST  = {12'h000, HALF_RST, CAR_RST, TERM_RST,
                                       SRC_RST, RATE_PAT[RATE_IDX_RST]};
   localparam logic [31:0] CFG_WMASK = 32'h000f_ffff;
   typedef enum logic [1:0] {
      SRC_INTERNAL, SRC_RECOVERED, SRC_EXTERNAL} sld_src_t;
   typedef enum logic [1:0] {CAR_OFF, CAR_WAIT, CAR_ON} sld_car_t;

   function automatic logic [DIV_W-1:0] half_period(logic [3:0] idx);
      return DIV_W'(CORE_CLK_HZ / (2 * RATE_BPS[idx]));
   endfunction
endpackage

// ===== hw/sld_ctrl.sv
// Control logic of a synchronous V.35 to RS-485 line driver.
//
// Summary of operation
// - Ten line rates, 56 Kbps after reset.
// - Twelve speed switch bits decode one rate.
// - Three clock sources, internal by default.
// - One-hot source switches: recovered, internal, external.
// - Internal mode generates transmit clock at rate.
// - Recovered mode aligns clock to received data.
// - External mode echoes terminal clock back out.
// - One bit enables termination, enabled by default.
// - Carrier jumper: constant or four switched delays.
// - Constant carrier: transmitter, CTS, RTS indicator on.
// - Switched: transmitter and carrier follow RTS.
// - Switched: CTS rises after configured delay.
// - Delays 0, 11, 50, 175 ms; 11 default.
// - One bit selects half or full duplex.
// - Carrier detect follows remote unit's RTS.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
module sld_ctrl
   import sld_pkg::*;
#(
   parameter int unsigned DLY_A_CYC = DLY_A_MS * CYC_PER_MS,
   parameter int unsigned DLY_B_CYC = DLY_B_MS * CYC_PER_MS,
   parameter int unsigned DLY_C_CYC = DLY_C_MS * CYC_PER_MS,
   parameter int unsigned DLY_D_CYC = DLY_D_MS * CYC_PER_MS
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [AXI_AW-1:0] i_awaddr,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   output logic [1:0]             o_bresp,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   input  wire logic [AXI_AW-1:0] i_araddr,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   input  wire logic              i_rts,
   input  wire logic              i_txd,
   input  wire logic              i_line_rxd,
   input  wire logic              i_remote_rts,
   input  wire logic              i_ext_clock_in_a,
   input  wire logic              i_ext_clock_in_b,
   output logic                   o_cts,
   output logic                   o_rxd,
   output logic                   o_dcd,
   output logic                   o_rts_led,
   output logic                   o_line_txd,
   output logic                   o_line_tx_en,
   output logic                   o_line_rts,
   output logic                   o_rx_en,
   output logic                   o_term_en,
   output logic                   o_tx_clock_out_a,
   output logic                   o_tx_clock_out_b
);
   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   logic [SYNC_N-1:0] meta_ff;
   logic [SYNC_N-1:0] sync_ff;
   wire  [SYNC_N-1:0] pins = {i_ext_clock_in_b, i_ext_clock_in_a,
                              i_remote_rts, i_line_rxd, i_txd, i_rts};
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= pins;
         sync_ff <= meta_ff;
      end
   end
   wire rts_s   = sync_ff[0];
   wire txd_s   = sync_ff[1];
   wire rxd_s   = sync_ff[2];
   wire rrts_s  = sync_ff[3];
   wire exta_s  = sync_ff[4];
   wire extb_s  = sync_ff[5];

   // ********************************************************************
   // Configuration decode
   // ********************************************************************
   logic [31:0] cfg_ff;
   logic [3:0]  rate_idx_ff;

   function automatic logic [4:0] decode_rate(logic [11:0] pat);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < NUM_RATES; i++) begin
         if (pat == RATE_PAT[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   wire [4:0] rate_dec = decode_rate(cfg_ff[CFG_RATE_LSB +: 12]);
   wire [2:0] src_sw   = cfg_ff[CFG_SRC_LSB +: 3];
   wire [2:0] car_sel  = cfg_ff[CFG_CAR_LSB +: 3];
   wire       half_dup = cfg_ff[CFG_HALF_BIT];
   // Patterns that are not exactly one-hot fall back to internal timing.
   wire sld_src_t src = (src_sw == 3'h1) ? SRC_RECOVERED :
                        (src_sw == 3'h4) ? SRC_EXTERNAL :
                        SRC_INTERNAL;
   wire constant_car = (car_sel == CAR_CONST);
   wire [DLY_CNT_W-1:0] dly_cyc =
      (car_sel == 3'h1) ? DLY_CNT_W'(DLY_A_CYC) :
      (car_sel == 3'h3) ? DLY_CNT_W'(DLY_C_CYC) :
      (car_sel == 3'h4) ? DLY_CNT_W'(DLY_D_CYC) :
      DLY_CNT_W'(DLY_B_CYC);

   // An unlisted switch pattern keeps the last good rate, so moving
   // switches one at a time never stops the clock.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         rate_idx_ff <= RATE_IDX_RST;
      end else if (rate_dec[4]) begin
         rate_idx_ff <= rate_dec[3:0];
      end
   end

   // ********************************************************************
   // Transmit clock generation
   // ********************************************************************
   logic [DIV_W-1:0] div_ff;
   logic             gen_clk_ff;
   logic             rxd_d_ff;
   logic             ext_lvl_ff;
   logic             tclk_a_ff;
   logic             tclk_b_ff;

   wire [DIV_W-1:0] half_cyc = half_period(rate_idx_ff);
   wire rx_edge  = (rxd_s != rxd_d_ff) && (src == SRC_RECOVERED);
   wire div_wrap = (div_ff == '0);
   // A data edge restarts the half period low, so the rising clock edge
   // lands in the middle of each received bit.
   wire [DIV_W-1:0] nxt_div = (rx_edge | div_wrap) ?
                              half_cyc - DIV_W'(1) : div_ff - DIV_W'(1);
   wire nxt_gen_clk = rx_edge ? 1'b0 :
                      div_wrap ? ~gen_clk_ff : gen_clk_ff;
   // The external pair is only trusted while its halves disagree.
   wire nxt_ext_lvl = (exta_s != extb_s) ? exta_s : ext_lvl_ff;
   wire nxt_tclk = (src == SRC_EXTERNAL) ? ext_lvl_ff : gen_clk_ff;

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         div_ff     <= '0;
         gen_clk_ff <= 1'b0;
         rxd_d_ff   <= 1'b0;
         ext_lvl_ff <= 1'b0;
         tclk_a_ff  <= 1'b0;
         tclk_b_ff  <= 1'b1;
      end else begin
         div_ff     <= nxt_div;
         gen_clk_ff <= nxt_gen_clk;
         rxd_d_ff   <= rxd_s;
         ext_lvl_ff <= nxt_ext_lvl;
         tclk_a_ff  <= nxt_tclk;
         tclk_b_ff  <= ~nxt_tclk;
      end
   end

   // ********************************************************************
   // Carrier and RTS to CTS handshake
   // ********************************************************************
   sld_car_t             car_ff;
   sld_car_t             nxt_car;
   logic [DLY_CNT_W-1:0] dly_ff;
   logic                 cts_ff;
   logic                 tx_en_ff;
   logic                 rx_en_ff;
   logic                 dcd_ff;
   logic                 line_txd_ff;
   logic                 rxd_out_ff;
   logic                 term_ff;

   always_comb begin
      nxt_car = car_ff;
      case (car_ff)
         CAR_OFF: begin
            if (rts_s) begin
               nxt_car = (dly_cyc == '0) ? CAR_ON : CAR_WAIT;
            end
         end
         CAR_WAIT: begin
            if (!rts_s) begin
               nxt_car = CAR_OFF;
            end else if (dly_ff == dly_cyc - DLY_CNT_W'(1)) begin
               nxt_car = CAR_ON;
            end
         end
         CAR_ON: begin
            if (!rts_s) begin
               nxt_car = CAR_OFF;
            end
         end
         default: nxt_car = CAR_OFF;
      endcase
   end

   wire [DLY_CNT_W-1:0] nxt_dly = (car_ff == CAR_WAIT) ?
                                  dly_ff + DLY_CNT_W'(1) : '0;
   wire nxt_tx_en = constant_car | rts_s;
   wire nxt_cts   = constant_car | (nxt_car == CAR_ON);
   wire nxt_rx_en = ~half_dup | ~nxt_tx_en;
   // Idle line marks; in half duplex our own echo is not passed back.
   wire nxt_ltxd  = tx_en_ff ? txd_s : 1'b1;
   wire nxt_rxd   = rx_en_ff ? rxd_s : 1'b1;

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         car_ff      <= CAR_OFF;
         dly_ff      <= '0;
         cts_ff      <= 1'b0;
         tx_en_ff    <= 1'b0;
         rx_en_ff    <= 1'b1;
         dcd_ff      <= 1'b0;
         line_txd_ff <= 1'b1;
         rxd_out_ff  <= 1'b1;
         term_ff     <= TERM_RST;
      end else begin
         car_ff      <= nxt_car;
         dly_ff      <= nxt_dly;
         cts_ff      <= nxt_cts;
         tx_en_ff    <= nxt_tx_en;
         rx_en_ff    <= nxt_rx_en;
         dcd_ff      <= rrts_s;
         line_txd_ff <= nxt_ltxd;
         rxd_out_ff  <= nxt_rxd;
         term_ff     <= cfg_ff[CFG_TERM_BIT];
      end
   end

   // ********************************************************************
   // AXI4-Lite register slave
   // ********************************************************************
   logic              awready_ff;
   logic              wready_ff;
   logic              aw_held_ff;
   logic              w_held_ff;
   logic [AXI_AW-1:0] aw_addr_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              arready_ff;
   logic              rvalid_ff;
   logic [31:0]       rdata_ff;
   logic [1:0]        rresp_ff;
   wire  [31:0]       wmask;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign wmask[8*b +: 8] = {8{wstrb_ff[b]}};
      end
   endgenerate

   wire aw_take  = i_awvalid & awready_ff;
   wire w_take   = i_wvalid & wready_ff;
   wire do_wr    = aw_held_ff & w_held_ff;
   wire wr_cfg   = do_wr & (aw_addr_ff == REG_CFG);
   wire wr_known = (aw_addr_ff == REG_CFG) | (aw_addr_ff == REG_STAT);
   wire nxt_aw_held = (aw_held_ff | aw_take) & ~do_wr;
   wire nxt_w_held  = (w_held_ff | w_take) & ~do_wr;
   wire nxt_bvalid  = do_wr | (bvalid_ff & ~i_bready);
   wire [31:0] nxt_cfg = wr_cfg ?
      ((cfg_ff & ~wmask) | (wdata_ff & wmask)) & CFG_WMASK : cfg_ff;
   wire ar_take    = i_arvalid & arready_ff;
   wire nxt_rvalid = ar_take | (rvalid_ff & ~i_rready);
   wire [31:0] stat = {20'h00000, term_ff, rx_en_ff, dcd_ff, cts_ff,
                       tx_en_ff, src, rate_dec[4], rate_idx_ff};
   wire rd_cfg  = (i_araddr == REG_CFG);
   wire rd_stat = (i_araddr == REG_STAT);
   wire [31:0] rd_mux = rd_cfg ? cfg_ff : rd_stat ? stat : 32'h0000_0000;

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         aw_addr_ff <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         cfg_ff     <= CFG_RST;
      end else begin
         awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
         wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
         aw_held_ff <= nxt_aw_held;
         w_held_ff  <= nxt_w_held;
         if (aw_take) begin
            aw_addr_ff <= i_awaddr;
         end
         if (w_take) begin
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
         end
         bvalid_ff <= nxt_bvalid;
         if (do_wr) begin
            bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         cfg_ff <= nxt_cfg;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_rvalid;
         rvalid_ff  <= nxt_rvalid;
         if (ar_take) begin
            rdata_ff <= rd_mux;
            rresp_ff <= (rd_cfg | rd_stat) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign o_awready        = awready_ff;
   assign o_wready         = wready_ff;
   assign o_bvalid         = bvalid_ff;
   assign o_bresp          = bresp_ff;
   assign o_arready        = arready_ff;
   assign o_rvalid         = rvalid_ff;
   assign o_rdata          = rdata_ff;
   assign o_rresp          = rresp_ff;
   assign o_cts            = cts_ff;
   assign o_rxd            = rxd_out_ff;
   assign o_dcd            = dcd_ff;
   assign o_rts_led        = tx_en_ff;
   assign o_line_txd       = line_txd_ff;
   assign o_line_tx_en     = tx_en_ff;
   assign o_line_rts       = tx_en_ff;
   assign o_rx_en          = rx_en_ff;
   assign o_term_en        = term_ff;
   assign o_tx_clock_out_a = tclk_a_ff;
   assign o_tx_clock_out_b = tclk_b_ff;
endmodule

// ===== tb/sld_dte_model.sv
// Behavioural terminal and remote unit facing the control block.
module sld_dte_model (
   input  wire logic i_core_clk,
   input  wire logic i_cts,
   input  wire logic i_rts_req,
   input  wire logic i_ext_run,
   input  wire logic i_remote_on,
   input  wire logic i_rx_flip,
   output logic      o_rts,
   output logic      o_txd,
   output logic      o_ext_a,
   output logic      o_ext_b,
   output logic      o_remote_rts,
   output logic      o_line_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ext_ff = 1'b0;
   logic txd_ff = 1'b1;
   // The terminal toggles its data every core clock while i_cts is high, whatever rate the bench configures.
   assign o_rts        = i_rts_req;
   assign o_remote_rts = i_remote_on;
   assign o_line_rxd   = i_rx_flip;
   assign o_txd        = txd_ff;
   assign o_ext_a      = ext_ff;
   assign o_ext_b      = !ext_ff;
   // The terminal clock toggles every 32 ns while i_ext_run is high and stands still otherwise.
   initial begin
      #3;
      forever begin
         #32;
         if (i_ext_run) ext_ff = !ext_ff;
      end
   end
   // Data only after clear to send, marking otherwise.
   always @(posedge i_core_clk) begin
      txd_ff <= i_cts ? !txd_ff : 1'b1;
   end
endmodule

// ===== tb/sld_ctrl_checker.sv
// Concurrent checks on the ports of the line driver control block.
module sld_ctrl_checker (
   input wire logic       i_core_clk,
   input wire logic       i_reset,
   input wire logic       i_awvalid,
   input wire logic       i_wvalid,
   input wire logic       i_bready,
   input wire logic       i_arvalid,
   input wire logic       i_rready,
   input wire logic       i_rts,
   input wire logic       i_remote_rts,
   input wire logic       o_awready,
   input wire logic       o_wready,
   input wire logic       o_bvalid,
   input wire logic [1:0] o_bresp,
   input wire logic       o_arready,
   input wire logic       o_rvalid,
   input wire logic [31:0] o_rdata,
   input wire logic       o_cts,
   input wire logic       o_dcd,
   input wire logic       o_rts_led,
   input wire logic       o_line_txd,
   input wire logic       o_line_tx_en,
   input wire logic       o_line_rts,
   input wire logic       o_tx_clock_out_a,
   input wire logic       o_tx_clock_out_b
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   sequence wr_taken;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence rd_taken;
      i_arvalid && o_arready;
   endsequence
   a_wr_answer: assert property (wr_taken |=> !o_bvalid ##1 o_bvalid)
      else $error("write response not two edges after take");
   a_bresp_stand: assert property (o_bvalid && !i_bready |=>
      o_bvalid && $stable(o_bresp)) else $error("write response dropped");
   a_rd_answer: assert property (rd_taken |=> o_rvalid)
      else $error("read answer not one edge after take");
   a_rdata_stand: assert property (o_rvalid && !i_rready |=>
      o_rvalid && $stable(o_rdata)) else $error("read data dropped");
   a_led_tracks_en: assert property (o_rts_led == o_line_tx_en &&
      o_line_rts == o_line_tx_en) else $error("indicator differs");
   a_cts_needs_en: assert property (o_cts |-> o_line_tx_en)
      else $error("clear to send without transmitter");
   a_clock_pair: assert property (o_tx_clock_out_b == !o_tx_clock_out_a)
      else $error("transmit clock pair not inverse");
   a_dcd_follow: assert property (i_remote_rts [*5] |-> o_dcd)
      else $error("carrier detect missing");
   a_dcd_clear: assert property (!i_remote_rts [*5] |-> !o_dcd)
      else $error("carrier detect stuck");
   a_mark_idle: assert property (!o_line_tx_en [*2] |-> o_line_txd)
      else $error("line not marking while idle");
   a_rts_drop: assert property (!i_rts [*5] |-> o_cts == o_line_tx_en)
      else $error("clear to send left after drop");
endmodule
bind sld_ctrl sld_ctrl_checker u_chk (.i_core_clk, .i_reset, .i_awvalid,
   .i_wvalid, .i_bready, .i_arvalid, .i_rready, .i_rts, .i_remote_rts,
   .o_awready, .o_wready, .o_bvalid, .o_bresp, .o_arready, .o_rvalid,
   .o_rdata, .o_cts, .o_dcd, .o_rts_led, .o_line_txd, .o_line_tx_en,
   .o_line_rts, .o_tx_clock_out_a, .o_tx_clock_out_b);

// ===== tb/tb.sv
// Self-checking bench for the line driver control block.
module tb;
   import sld_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 0, i_reset = 1, i_awvalid = 0, i_wvalid = 0;
   logic i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic [7:0] i_awaddr = 0, i_araddr = 0;
   logic [31:0] i_wdata = 0, o_rdata, d;
   logic [3:0] i_wstrb = 4'hf;
   logic [1:0] o_bresp, o_rresp, r;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cts, o_rxd;
   logic o_dcd, o_rts_led, o_line_txd, o_line_tx_en, o_line_rts, o_rx_en;
   logic o_term_en, o_tx_clock_out_a, o_tx_clock_out_b;
   logic i_rts, i_txd, i_line_rxd, i_remote_rts;
   logic i_ext_clock_in_a, i_ext_clock_in_b;
   logic rts_req = 0, ext_run = 0, rem_on = 0, rx_flip = 0;
   int   miscompares = 0, tests_run = 0, te, tc;
   always #4 i_core_clk = !i_core_clk;
   sld_ctrl #(.DLY_A_CYC(0), .DLY_B_CYC(20), .DLY_C_CYC(50), .DLY_D_CYC(100))
   dut (.i_core_clk, .i_reset, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
      .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
      .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
      .o_rresp, .i_rts, .i_txd, .i_line_rxd, .i_remote_rts, .i_ext_clock_in_a,
      .i_ext_clock_in_b, .o_cts, .o_rxd, .o_dcd, .o_rts_led, .o_line_txd,
      .o_line_tx_en, .o_line_rts, .o_rx_en, .o_term_en, .o_tx_clock_out_a,
      .o_tx_clock_out_b);
   sld_dte_model peer (.i_core_clk, .i_cts(o_cts), .i_rts_req(rts_req),
      .i_ext_run(ext_run), .i_remote_on(rem_on), .i_rx_flip(rx_flip),
      .o_rts(i_rts), .o_txd(i_txd), .o_ext_a(i_ext_clock_in_a),
      .o_ext_b(i_ext_clock_in_b), .o_remote_rts(i_remote_rts),
      .o_line_rxd(i_line_rxd));
   // ********************************************************************
   // Reporting and comparison
   // ********************************************************************
   task automatic results;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic mism(input string m);
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic tout;
      mism("timeout");
      results();
   endtask
   task automatic chk_bit(input logic g, input logic e, input string m);
      tests_run++;
      if (g !== e) mism(m);
   endtask
   task automatic chk_word(input logic [31:0] g, e, input string m);
      tests_run++;
      if (g !== e) mism(m);
   endtask
   task automatic chk_cnt(input int g, e, input string m);
      tests_run++;
      if (g != e) mism(m);
   endtask
   // ********************************************************************
   // Bus and pin helpers
   // ********************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                         output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge i_core_clk);
      {i_awaddr, i_wdata} <= {a, v};
      {i_awvalid, i_wvalid, i_bready} <= 3'h7;
      do begin
         @(posedge i_core_clk);
         n++;
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1 && n < 200);
      rs = o_bresp;
      i_bready <= 1'b0;
      if (n >= 200) tout();
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                         output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge i_core_clk);
      i_araddr <= a;
      {i_arvalid, i_rready} <= 2'h3;
      do begin
         @(posedge i_core_clk);
         n++;
         if (o_arready) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1 && n < 200);
      {v, rs} = {o_rdata, o_rresp};
      i_rready <= 1'b0;
      if (n >= 200) tout();
   endtask
   function automatic logic [31:0] cfg(logic [11:0] p, logic [2:0] s,
                                       logic t, logic [2:0] c, logic h);
      return {12'h000, h, c, t, s, p};
   endfunction
   task automatic put(input logic [31:0] v);
      axi_wr(REG_CFG, v, r);
      chk_word(32'(r), 32'(RESP_OKAY), "config write response");
   endtask
   task automatic wait_lvl(input logic v, output int k);
      for (k = 0; k < 2000 && o_tx_clock_out_a !== v; k++) cyc(1);
      if (k >= 2000) tout();
   endtask
   task automatic rise_rts(output int t_en, output int t_cts);
      {t_en, t_cts} = 0;
      @(posedge i_core_clk);
      rts_req <= 1'b1;
      for (int k = 1; k < 300 && t_cts == 0; k++) begin
         cyc(1);
         if (o_line_tx_en === 1'b1 && t_en == 0) t_en = k;
         if (o_cts === 1'b1) t_cts = k;
      end
      if (t_cts == 0) tout();
   endtask
   task automatic drop_rts(output int t_cts);
      @(posedge i_core_clk);
      rts_req <= 1'b0;
      for (t_cts = 1; t_cts < 300 && o_cts === 1'b1; t_cts++) cyc(1);
      t_cts--;
   endtask
   // ********************************************************************
   // Scenarios
   // ********************************************************************
   task automatic t_reset;
      axi_rd(REG_CFG, d, r);
      chk_word(d, 32'h0002af50, "config reset");
      axi_rd(REG_STAT, d, r);
      chk_word(d & 32'h87f, 32'h815, "status reset");
      chk_bit(o_rx_en, 1'b1, "receiver off after reset");
      axi_rd(8'h08, d, r);
      chk_word({d[29:0], r}, 32'(RESP_SLVERR), "unmapped read");
      axi_wr(8'h08, 32'h1, r);
      chk_word(32'(r), 32'(RESP_SLVERR), "unmapped write");
   endtask
   task automatic t_rates;
      for (int i = 0; i < 10; i++) begin
         put(cfg(RATE_PAT[i], 3'h2, 1'b1, 3'h2, 1'b0));
         axi_rd(REG_STAT, d, r);
         chk_word(d & 32'h1f, 32'h10 | i, "rate decode");
      end
      put(cfg(12'h000, 3'h2, 1'b1, 3'h2, 1'b0));
      axi_rd(REG_STAT, d, r);
      chk_word(d & 32'h1f, 32'h09, "bad pattern keeps rate");
   endtask
   task automatic t_clocks;
      put(cfg(RATE_PAT[9], 3'h2, 1'b1, 3'h2, 1'b0));
      wait_lvl(1'b0, te);
      wait_lvl(1'b1, te);
      wait_lvl(1'b0, te);
      chk_cnt(te, CORE_CLK_HZ / (2 * RATE_BPS[9]), "half period");
      put(cfg(RATE_PAT[9], 3'h1, 1'b1, 3'h2, 1'b0));
      wait_lvl(1'b1, te);
      rx_flip <= !rx_flip;
      wait_lvl(1'b0, te);
      chk_cnt(te, 4, "recovered realign");
      put(cfg(RATE_PAT[9], 3'h4, 1'b1, 3'h2, 1'b0));
      ext_run <= 1'b1;
      wait_lvl(1'b0, te);
      wait_lvl(1'b1, te);
      wait_lvl(1'b0, te);
      chk_cnt(te, 4, "external echo");
      ext_run <= 1'b0;
      axi_rd(REG_STAT, d, r);
      chk_word(32'(d[6:5]), 32'h2, "external source");
      put(cfg(RATE_PAT[9], 3'h3, 1'b0, 3'h2, 1'b0));
      axi_rd(REG_STAT, d, r);
      chk_word(32'(d[6:5]), 32'h0, "bad source gives internal");
      chk_bit(o_term_en, 1'b0, "termination off");
   endtask
   task automatic t_const;
      logic a;
      put(cfg(RATE_PAT[5], 3'h2, 1'b1, CAR_CONST, 1'b0));
      cyc(4);
      chk_bit(o_cts & o_line_tx_en & o_rts_led, 1'b1, "constant");
      a = o_line_txd;
      cyc(1);
      chk_bit(o_line_txd, !a, "terminal data forwarded");
   endtask
   task automatic t_switched(input logic [2:0] j, input int n);
      put(cfg(RATE_PAT[5], 3'h2, 1'b1, j, 1'b0));
      rise_rts(te, tc);
      chk_cnt(te, 3, "transmitter latency");
      chk_cnt(tc, n + 3, "clear to send delay");
      drop_rts(tc);
      chk_cnt(tc, 3, "clear to send drop");
      chk_bit(o_line_tx_en | o_rts_led, 1'b0, "transmitter drop");
   endtask
   task automatic t_restart;
      @(posedge i_core_clk);
      rts_req <= 1'b1;
      cyc(10);
      drop_rts(tc);
      cyc(5);
      rise_rts(te, tc);
      chk_cnt(tc, 23, "delay restart");
      put(cfg(RATE_PAT[5], 3'h2, 1'b1, 3'h1, 1'b1));
      rx_flip <= 1'b0;
      cyc(4);
      chk_bit(o_rx_en, 1'b0, "half duplex receiver");
      chk_bit(o_rxd, 1'b1, "own echo masked");
      drop_rts(tc);
      cyc(2);
      chk_bit(o_rx_en, 1'b1, "half duplex idle");
      chk_bit(o_rxd, 1'b0, "receive data");
      rem_on <= 1'b1;
      cyc(5);
      chk_bit(o_dcd, 1'b1, "carrier detect on");
      rem_on <= 1'b0;
      cyc(5);
      chk_bit(o_dcd, 1'b0, "carrier detect off");
   endtask
   initial begin
      repeat (16) @(posedge i_core_clk);
      i_reset <= 1'b0;
      t_reset();
      t_rates();
      t_clocks();
      t_const();
      for (int j = 1; j < 6; j++) begin
         t_switched(3'(j), j == 1 ? 0 : j == 3 ? 50 : j == 4 ? 100 : 20);
      end
      t_restart();
      results();
   end
   initial begin
      #400000;
      tout();
   end
endmodule
